// File: verilog/shared_bus_pkg.sv
// Constants and types for the shared flash and SRAM bus controller
package shared_bus_pkg;
  localparam int ADDR_W = 26;
  localparam int DATA_W = 32;
  localparam int NOR_DATA_W = 16;
  localparam int NOR_ADDR_LSB = 1;
  localparam int NOR_ADDR_W = 25;
  localparam int SRAM_ADDR_LSB = 2;
  localparam int SRAM_ADDR_W = 21;
  localparam int LANES = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int CLK_MHZ = 100;
  localparam int NOR_MAX_MHZ = 40;
  // Flash clock half period in system cycles, rounded up so the clock stays at or below 40 MHz
  localparam int NOR_HALF = (CLK_MHZ + 2 * NOR_MAX_MHZ - 1) / (2 * NOR_MAX_MHZ);
  localparam logic [3:0] NOR_HALF_CNT = 4'(NOR_HALF);
  // Asynchronous read access time in nanoseconds, then in system cycles
  localparam int NOR_ASYNC_NS = 110;
  localparam logic [3:0] NOR_ASYNC_CNT = 4'((NOR_ASYNC_NS * CLK_MHZ + 999) / 1000);
  localparam logic [4:0] BURST_4 = 5'h04;
  localparam logic [4:0] BURST_8 = 5'h08;
  localparam logic [4:0] BURST_16 = 5'h10;
  localparam logic [1:0] BL_4 = 2'h0;
  localparam logic [1:0] BL_8 = 2'h1;
  localparam logic [1:0] BL_16 = 2'h2;
  localparam logic [1:0] BL_CONT = 2'h3;
  localparam logic [3:0] LANES_NONE = 4'hf;
  typedef enum logic [1:0] {
    CMD_NOR_READ = 2'h0,
    CMD_NOR_WRITE = 2'h1,
    CMD_SRAM_READ = 2'h2,
    CMD_SRAM_WRITE = 2'h3
  } cmd_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_DATA = 3'h3,
    ST_TURN = 3'h2,
    ST_WAIT = 3'h6
  } state_type;
endpackage

// File: verilog/stream_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
module stream_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;
  assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// File: verilog/shared_flash_sram_bus_ctrl.sv
// Controller for the shared flash, SRAM and system-controller memory bus
//
// Overview of operation
// - Flash words are 16 bits on the low half of the shared data lines.
// - Flash bursts of 4, 8, 16 or continuous words, length chosen beforehand.
// - Synchronous flash data comes with no wait states up to a 40 MHz flash clock.
// - After reset the flash reads asynchronously until burst mode is configured.
// - One shared address/data/OE/WE set; only the selected device drives data.
`timescale 1ns/1ps
module shared_flash_sram_bus_ctrl
  import shared_bus_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Command side
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_wdata,
  input wire logic [LANES-1:0] cmd_lanes,
  input wire logic [4:0] cmd_len,
  input wire logic sync_mode,
  input wire logic [1:0] burst_len_sel,
  input wire logic write_allow,
  input wire logic bus_grant_other,
  // Read data stream
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [DATA_W-1:0] rd_data,
  // Shared bus
  output logic [ADDR_W-1:0] shared_addr_line,
  input wire logic [DATA_W-1:0] shared_data_line_in,
  output logic [DATA_W-1:0] shared_data_line_out,
  output logic shared_data_line_oe,
  output logic shared_output_enable_low,
  output logic shared_write_enable_low,
  // Flash controls
  output logic nor_clock,
  output logic nor_reset_low,
  output logic nor_select_low,
  output logic nor_addr_valid_low,
  output logic nor_write_protect_low,
  input wire logic nor_ready_indication,
  // SRAM controls
  output logic sram_clock,
  output logic sram_select_low,
  output logic sram_ctrl_addr_strobe_low,
  output logic sram_cpu_addr_strobe_low,
  output logic sram_burst_advance_low,
  output logic sram_byte_lane0_write_low,
  output logic sram_byte_lane1_write_low,
  output logic sram_byte_lane2_write_low,
  output logic sram_byte_lane3_write_low
);
  state_type state;
  logic [1:0] op;
  logic [4:0] left;
  logic [3:0] cnt;
  logic [3:0] half;
  logic rdy_s1;
  logic rdy_s2;
  logic grant_s1;
  logic grant_s2;
  logic cap_valid;
  logic [DATA_W-1:0] cap_data;
  logic fifo_ready;
  logic [4:0] burst_words;
  logic link_edge;
  logic is_nor;
  logic take;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [DATA_W-1:0] fifo_out_data;

  // Ready and bus grant come from outside the clock domain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
      grant_s1 <= 1'b0;
      grant_s2 <= 1'b0;
    end else begin
      rdy_s1 <= nor_ready_indication;
      rdy_s2 <= rdy_s1;
      grant_s1 <= bus_grant_other;
      grant_s2 <= grant_s1;
    end
  end

  always_comb begin
    case (burst_len_sel)
      BL_4: burst_words = BURST_4;
      BL_8: burst_words = BURST_8;
      BL_16: burst_words = BURST_16;
      default: burst_words = cmd_len;
    endcase
  end

  // Link clock divider; both memory clocks share it, kept at or below 40 MHz
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      half <= '0;
      nor_clock <= 1'b0;
      sram_clock <= 1'b0;
    end else if (half == NOR_HALF_CNT - 4'h1) begin
      half <= '0;
      nor_clock <= !nor_clock;
      sram_clock <= !sram_clock;
    end else begin
      half <= half + 4'h1;
    end
  end
  // Act at the falling edge so pins settle half a link period before the rising edge
  assign link_edge = (half == NOR_HALF_CNT - 4'h1) && nor_clock;
  // Another master owns the bus, or the flash is busy
  assign take = (state == ST_IDLE) && cmd_valid && !grant_s2 && (rdy_s2 || cmd_op[1]) &&
                link_edge && !cmd_ready;
  assign is_nor = !op[1];

  // Sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      op <= CMD_NOR_READ;
      left <= '0;
      cnt <= '0;
      cmd_ready <= 1'b0;
    end else begin
      cmd_ready <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (take) begin
            op <= cmd_op;
            // Reads burst once sync mode is set; the SRAM follows the same length
            left <= (!cmd_op[0] && sync_mode) ? burst_words : 5'h01;
            cmd_ready <= 1'b1;
            state <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (link_edge) begin
            cnt <= '0;
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (is_nor && !sync_mode && cnt < NOR_ASYNC_CNT) begin
            cnt <= cnt + 4'h1;
          end else if (link_edge && fifo_ready) begin
            left <= left - 5'h01;
            if (left == 5'h01) begin
              state <= ST_TURN;
            end
          end
        end
        ST_TURN: begin
          if (link_edge) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Capture read data into the FIFO; the FIFO back-pressure stalls the burst
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cap_valid <= 1'b0;
      cap_data <= '0;
    end else begin
      cap_valid <= 1'b0;
      if (state == ST_DATA && !op[0] && link_edge && fifo_ready &&
          !(is_nor && !sync_mode && cnt < NOR_ASYNC_CNT)) begin
        cap_valid <= 1'b1;
        cap_data <= is_nor ? {{(DATA_W-NOR_DATA_W){1'b0}}, shared_data_line_in[NOR_DATA_W-1:0]}
                           : shared_data_line_in;
      end
    end
  end

  // Bus pins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shared_addr_line <= '0;
      shared_data_line_out <= '0;
      shared_data_line_oe <= 1'b0;
      shared_output_enable_low <= 1'b1;
      shared_write_enable_low <= 1'b1;
      nor_reset_low <= 1'b0;
      nor_select_low <= 1'b1;
      nor_addr_valid_low <= 1'b1;
      nor_write_protect_low <= 1'b0;
      sram_select_low <= 1'b1;
      sram_ctrl_addr_strobe_low <= 1'b1;
      sram_cpu_addr_strobe_low <= 1'b1;
      sram_burst_advance_low <= 1'b1;
      {sram_byte_lane3_write_low, sram_byte_lane2_write_low,
       sram_byte_lane1_write_low, sram_byte_lane0_write_low} <= LANES_NONE;
    end else begin
      nor_reset_low <= 1'b1;
      nor_write_protect_low <= write_allow;
      sram_cpu_addr_strobe_low <= 1'b1;
      // Strobes stand a whole link period so a rising memory clock edge sees them
      if (link_edge) begin
        nor_addr_valid_low <= 1'b1;
        sram_ctrl_addr_strobe_low <= 1'b1;
        sram_burst_advance_low <= 1'b1;
      end
      if (take) begin
        if (!cmd_op[1]) begin
          shared_addr_line <= {cmd_addr[NOR_ADDR_W-1:0], 1'b0};
          nor_select_low <= 1'b0;
          nor_addr_valid_low <= 1'b0;
        end else begin
          shared_addr_line <= {3'h0, cmd_addr[SRAM_ADDR_W-1:0], 2'h0};
          sram_select_low <= 1'b0;
          sram_ctrl_addr_strobe_low <= 1'b0;
        end
        shared_data_line_out <= cmd_wdata;
        shared_data_line_oe <= cmd_op[0];
        shared_output_enable_low <= cmd_op[0];
        shared_write_enable_low <= !cmd_op[0];
        if (cmd_op == CMD_SRAM_WRITE) begin
          {sram_byte_lane3_write_low, sram_byte_lane2_write_low,
           sram_byte_lane1_write_low, sram_byte_lane0_write_low} <= ~cmd_lanes;
        end
      end else if (state == ST_DATA && link_edge && fifo_ready && op[1] && left != 5'h01) begin
        sram_burst_advance_low <= 1'b0;
      end else if (state == ST_TURN) begin
        // Release data and OE first, chip enables after, before another device
        shared_data_line_oe <= 1'b0;
        shared_output_enable_low <= 1'b1;
        shared_write_enable_low <= 1'b1;
        {sram_byte_lane3_write_low, sram_byte_lane2_write_low,
         sram_byte_lane1_write_low, sram_byte_lane0_write_low} <= LANES_NONE;
        if (link_edge) begin
          nor_select_low <= 1'b1;
          sram_select_low <= 1'b1;
        end
      end
    end
  end

  // Output register keeps the read stream pins straight from flip-flops
  assign fifo_out_ready = !rd_valid || rd_ready;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else if (fifo_out_ready) begin
      rd_valid <= fifo_out_valid;
      rd_data <= fifo_out_data;
    end
  end

  stream_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rd_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(cap_valid),
    .in_ready(fifo_ready),
    .in_data(cap_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );
endmodule

// File: verification/bus_ctrl_properties.sv
// Port-level checks on the shared flash and SRAM bus controller
`timescale 1ns/1ps
module bus_ctrl_checker (
  // Clock, reset and requests
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic write_allow,
  input wire logic bus_grant_other,
  // Bus and device controls
  input wire logic shared_data_line_oe,
  input wire logic shared_output_enable_low,
  input wire logic nor_clock,
  input wire logic nor_select_low,
  input wire logic nor_write_protect_low,
  input wire logic nor_ready_indication,
  input wire logic sram_select_low,
  input wire logic sram_ctrl_addr_strobe_low,
  input wire logic sram_burst_advance_low
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // Two system cycles high keeps the flash clock at or below its rated rate
  sequence clk_high_two;
    nor_clock [*2];
  endsequence
  a_one_select: assert property (nor_select_low || sram_select_low)
    else $error("both chip selects active");
  a_drive_no_read: assert property (shared_data_line_oe |-> shared_output_enable_low)
    else $error("data driven while output enable low");
  a_read_has_select: assert property (
      !shared_output_enable_low |-> !(nor_select_low && sram_select_low))
    else $error("output enable without a select");
  a_nor_clk_rate: assert property ($rose(nor_clock) |-> clk_high_two)
    else $error("flash clock too fast");
  a_ready_pulse: assert property (cmd_ready |=> !cmd_ready)
    else $error("request taken back to back");
  a_grant_blocks: assert property (bus_grant_other [*5] |-> !cmd_ready)
    else $error("request taken while other master owns bus");
  a_wait_ready: assert property (
      !nor_ready_indication [*5] |=> !(cmd_ready && !cmd_op[1]))
    else $error("flash request taken while flash busy");
  a_wp_follows: assert property (!write_allow [*3] |-> !nor_write_protect_low)
    else $error("write protect released without permission");
  a_strobe_has_sel: assert property (!sram_ctrl_addr_strobe_low |-> !sram_select_low)
    else $error("address strobe without SRAM select");
  a_advance_has_sel: assert property (!sram_burst_advance_low |-> !sram_select_low)
    else $error("burst advance without SRAM select");
endmodule

bind shared_flash_sram_bus_ctrl bus_ctrl_checker bus_ctrl_checker_inst (.*);

// File: verification/shared_mem_model.sv
// Behavioural flash and SRAM on the far side of the shared bus
`timescale 1ns/1ps
module shared_mem_model (
  // Clocks
  input wire logic clk,
  input wire logic sram_clock,
  // Shared bus
  input wire logic [25:0] addr,
  input wire logic [31:0] wdata,
  input wire logic oe_low,
  input wire logic we_low,
  output logic [31:0] rdata,
  // Device selects
  input wire logic nor_sel_low,
  input wire logic sram_sel_low,
  input wire logic [3:0] lanes_low,
  // SRAM burst controls
  input wire logic strobe_low,
  input wire logic adv_low
);
  logic [31:0] mem [16];
  logic [31:0] last = 32'h0000_0000;
  logic [3:0] ofs = 4'h0;
  // Burst offset restarts on the address strobe and steps on advance
  always_ff @(posedge sram_clock) begin
    if (!strobe_low) ofs <= 4'h0;
    else if (!sram_sel_low && !adv_low) ofs <= ofs + 4'h1;
  end
  always_ff @(posedge sram_clock) begin
    if (!sram_sel_low && !we_low) begin
      for (int i = 0; i < 4; i++) begin
        if (!lanes_low[i]) mem[addr[5:2]][8*i+:8] <= wdata[8*i+:8];
      end
    end
  end
  // Released lines show the inverse of the last value, so a stale copy never passes
  always_ff @(posedge clk) last <= rdata;
  always_comb begin
    rdata = ~last;
    if (!nor_sel_low && !oe_low) rdata[15:0] = addr[16:1] ^ 16'h5a5a;
    if (!sram_sel_low && !oe_low) rdata = mem[addr[5:2] + ofs];
  end
endmodule

// File: verification/tb_top.sv
// Self-checking bench for the shared flash and SRAM bus controller
`timescale 1ns/1ps
module tb_top;
  import shared_bus_pkg::*;
  logic clk, rst_b, cmd_valid, cmd_ready, sync_mode, write_allow, bus_grant_other;
  logic rd_valid, rd_ready, shared_data_line_oe, shared_output_enable_low;
  logic [1:0] cmd_op, burst_len_sel;
  logic [25:0] cmd_addr, shared_addr_line;
  logic [31:0] cmd_wdata, rd_data, shared_data_line_in, shared_data_line_out;
  logic [3:0] cmd_lanes;
  logic [4:0] cmd_len;
  logic shared_write_enable_low, nor_clock, nor_reset_low, nor_select_low;
  logic nor_addr_valid_low, nor_write_protect_low, nor_ready_indication, sram_clock;
  logic sram_select_low, sram_ctrl_addr_strobe_low, sram_cpu_addr_strobe_low;
  logic sram_burst_advance_low, sram_byte_lane0_write_low, sram_byte_lane1_write_low;
  logic sram_byte_lane2_write_low, sram_byte_lane3_write_low;
  int bad_count = 0;
  int checks = 0;
  logic [31:0] got [$];
  shared_flash_sram_bus_ctrl shared_flash_sram_bus_ctrl_inst (.*);
  shared_mem_model shared_mem_model_inst (.clk(clk), .sram_clock(sram_clock),
    .addr(shared_addr_line), .wdata(shared_data_line_out), .oe_low(shared_output_enable_low),
    .we_low(shared_write_enable_low), .rdata(shared_data_line_in),
    .nor_sel_low(nor_select_low), .sram_sel_low(sram_select_low),
    .lanes_low({sram_byte_lane3_write_low, sram_byte_lane2_write_low,
      sram_byte_lane1_write_low, sram_byte_lane0_write_low}),
    .strobe_low(sram_ctrl_addr_strobe_low), .adv_low(sram_burst_advance_low));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Holds the request until the taken pulse is sampled, then releases it
  task automatic issue(input logic [1:0] op, input logic [25:0] a, input logic [31:0] d,
      input logic [3:0] ln);
    int n;
    @(negedge clk);
    {cmd_op, cmd_addr, cmd_wdata, cmd_lanes} = {op, a, d, ln};
    cmd_valid = 1'b1;
    for (n = 0; n < 300 && cmd_ready !== 1'b1; n++) @(negedge clk);
    check(32'(cmd_ready), 32'h0000_0001);
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask
  task automatic drain(input int n);
    got.delete();
    rd_ready = 1'b1;
    // Sample before each wait so a word already standing is not lost
    for (int i = 0; i < 3000 && got.size() < n; i++) begin
      if (rd_valid === 1'b1) got.push_back(rd_data);
      @(negedge clk);
    end
    // Keep collecting so a surplus word is caught
    repeat (20) begin
      if (rd_valid === 1'b1) got.push_back(rd_data);
      @(negedge clk);
    end
    check(32'({got.size(), rd_valid}), 32'({n, 1'b0}));
  endtask
  task automatic t_reset();
    repeat (16) @(negedge clk);
    check(32'(nor_reset_low), 32'h0000_0000);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    check(32'({nor_reset_low, nor_select_low, sram_select_low, shared_data_line_oe}),
      32'h0000_000e);
  endtask
  task automatic t_flash_read(input logic [25:0] a);
    issue(CMD_NOR_READ, a, 32'h0000_0000, 4'hf);
    drain(1);
    check(got[0], {16'h0000, a[15:0] ^ 16'h5a5a});
  endtask
  task automatic t_sram();
    write_allow = 1'b1;
    issue(CMD_NOR_WRITE, 26'h000_0010, 32'h0000_beef, 4'h3);
    check(32'({nor_write_protect_low, nor_addr_valid_low, nor_select_low,
      shared_write_enable_low, shared_data_line_oe}), 32'h0000_0011);
    check(32'(shared_addr_line), 32'h0000_0020);
    check(shared_data_line_out, 32'h0000_beef);
    repeat (40) @(negedge clk);
    write_allow = 1'b0;
    issue(CMD_SRAM_WRITE, 26'h000_0003, 32'h1122_3344, 4'hf);
    repeat (30) @(negedge clk);
    issue(CMD_SRAM_WRITE, 26'h000_0003, 32'haabb_ccdd, 4'h5);
    check(32'({sram_byte_lane3_write_low, sram_byte_lane2_write_low, sram_byte_lane1_write_low,
      sram_byte_lane0_write_low, sram_ctrl_addr_strobe_low, sram_select_low}),
      32'h0000_0028);
    check(32'(shared_addr_line), 32'h0000_000c);
    repeat (30) @(negedge clk);
    issue(CMD_SRAM_WRITE, 26'h000_0004, 32'h5566_7788, 4'hf);
    repeat (30) @(negedge clk);
    issue(CMD_SRAM_READ, 26'h000_0003, 32'h0000_0000, 4'hf);
    drain(1);
    check(got[0], 32'h11bb_33dd);
    // Two-word SRAM burst: the second word only reads back right if advance steps the address
    {sync_mode, burst_len_sel, cmd_len} = {1'b1, BL_CONT, 5'h02};
    issue(CMD_SRAM_READ, 26'h000_0003, 32'h0000_0000, 4'hf);
    drain(2);
    check(got[0], 32'h11bb_33dd);
    check(got[1], 32'h5566_7788);
    sync_mode = 1'b0;
  endtask
  // Grant high means the other master owns the bus; grant low means the flash is busy
  task automatic t_refused(input logic grant);
    logic hit;
    hit = 1'b0;
    bus_grant_other = grant;
    nor_ready_indication = grant;
    repeat (4) @(negedge clk);
    fork
      t_flash_read(26'h000_0042);
      begin
        repeat (40) begin
          @(negedge clk);
          if (cmd_ready === 1'b1) hit = 1'b1;
        end
        @(negedge clk);
        bus_grant_other = 1'b0;
        nor_ready_indication = 1'b1;
      end
    join
    check(32'(hit), 32'h0000_0000);
  endtask
  // With the reader stalled the FIFO fills and the burst must wait, not drop words
  task automatic t_burst(input logic [1:0] sel, input int n, input logic stall);
    sync_mode = 1'b1;
    burst_len_sel = sel;
    cmd_len = 5'h14;
    rd_ready = ~stall;
    issue(CMD_NOR_READ, 26'h000_0100, 32'h0000_0000, 4'hf);
    if (stall) begin
      repeat (300) @(negedge clk);
      check(32'(rd_valid), 32'h0000_0001);
    end
    drain(n);
    foreach (got[i]) check(32'(got[i][31:16]), 32'h0000_0000);
  endtask
  initial begin
    {cmd_valid, cmd_op, cmd_addr, cmd_wdata, cmd_lanes, cmd_len} = '0;
    {sync_mode, burst_len_sel, write_allow, bus_grant_other} = '0;
    rst_b = 1'b0;
    nor_ready_indication = 1'b1;
    rd_ready = 1'b1;
    t_reset();
    t_flash_read(26'h000_1234);
    t_flash_read(26'h000_edcb);
    t_sram();
    t_refused(1'b1);
    t_refused(1'b0);
    t_burst(BL_4, 4, 1'b0);
    t_burst(BL_8, 8, 1'b0);
    t_burst(BL_16, 16, 1'b0);
    t_burst(BL_CONT, 20, 1'b1);
    results();
  end
  initial begin
    #300_000;
    bad_count++;
    results();
  end
endmodule
